// *** cml_cpu_model.sv ***
// Purpose: processor model on the register bus of the macrocell array
// Assumes: one clock; requests change just after a rising edge
// Notes: released address and data show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module cml_cpu_model (
  input wire logic clock,
  output logic register_block_select,
  output logic [7:0] reg_addr,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_data_oe
);
  initial begin
    register_block_select = 1'b0;
    reg_addr = 8'h00;
    wr_strobe_n = 1'b1;
    rd_strobe_n = 1'b1;
    wr_data = 8'h00;
  end
  // callers load masks before group writes so state cells survive
  task automatic wr(input logic [7:0] a, input logic [7:0] w, input logic sel, input int hold);
    @(posedge clock);
    register_block_select <= sel;
    reg_addr <= a;
    wr_data <= w;
    wr_strobe_n <= 1'b0;
    repeat (hold) @(posedge clock);
    register_block_select <= 1'b0;
    wr_strobe_n <= 1'b1;
    reg_addr <= ~a;
    wr_data <= ~w;
  endtask
  // answer is taken one step after the taking edge, once registered outputs settled
  task automatic rd(input logic [7:0] a, output logic [7:0] r, output logic v);
    @(posedge clock);
    register_block_select <= 1'b1;
    reg_addr <= a;
    rd_strobe_n <= 1'b0;
    @(posedge clock);
    #1;
    r = rd_data;
    v = rd_data_oe;
    @(posedge clock);
    register_block_select <= 1'b0;
    rd_strobe_n <= 1'b1;
    reg_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// *** cml_macrocell_array.sv ***
// Purpose: output and input macrocells of the logic array with processor load/read
// Assumes: product terms arrive from the and array on this clock; pins are asynchronous
// Notes: asynchronous preset/clear and flip-flop clocks are modelled as sampled events
// Functional notes
// RL1: two groups of eight output cells; group ab to ports a/b, bc to b/c.
// RL2: each sum passes an xor whose other input sets polarity.
// RL3: selector picks flop or sum; result drives pin and feeds back.
// RL4: each output flop acts as d, t, jk or sr element.
// RL5: clock from product term or rising edge of the logic clock pin.
// RL6: preset and clear active high; clear is or of two terms.
// RL7: ab cells own three terms borrow six; bc own four borrow five/six.
// RL8: borrow only from neighbours; a used term is never granted elsewhere.
// RL9: expansion through another output cell costs one extra cell delay.
// RL10: processor load overrides clock, preset and clear of written cells.
// RL11: cell n of each group maps to data bit n.
// RL12: load captured at trailing write edge or throughout active strobe.
// RL13: per-group load mask resets to zero; set bit blocks processor load.
// RL14: pin enable is or of enable term and direction bit.
// RL15: logic output without enable equation drives from power-up.
// RL16: internal node never drives its pin but still feeds back.
// RL17: small package maps ab to port b; port c 0,1,5,6 never used.
// RL18: twenty input cells: latch, edge register or pass-through.
// RL19: input cell enable chosen between product term and address latch strobe.
// RL20: one term per four input cells: bits 3-0 and 7-4.
// RL21: input cell outputs feed the logic and are processor readable.
// RL22: register accesses qualified by the register block select.
// RL23: register offsets are implementation constants.
// RL24: software masks state-machine cells before group writes.
`timescale 1ns/1ps
`default_nettype none
module cml_macrocell_array (
  input wire logic clock,
  input wire logic nrst,
  input wire logic register_block_select,
  input wire logic [7:0] reg_addr,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_data_oe,
  input wire logic edge_load,
  input wire logic addr_latch_strobe,
  input wire logic logic_clock_input,
  input wire logic [63:0] term_val,
  input wire logic [63:0] term_own,
  input wire logic [63:0] term_lend,
  input wire logic [63:0] term_lend_up,
  input wire logic [15:0] expand_en,
  input wire logic [15:0] polarity,
  input wire logic [15:0] reg_sel,
  input wire cml_pkg::cml_ff_t ff_type [16],
  input wire logic [15:0] k_sum,
  input wire logic [15:0] clk_term,
  input wire logic [15:0] clk_from_pin,
  input wire logic [15:0] preset_term,
  input wire logic [31:0] clear_term,
  input wire logic [15:0] pin_output,
  input wire logic [15:0] oe_defined,
  input wire logic [15:0] oe_term,
  input wire logic [15:0] internal_node,
  input wire logic [7:0] ab_to_b,
  input wire logic [7:0] bc_to_c,
  input wire logic small_package,
  input wire logic [7:0] dir_a,
  input wire logic [7:0] dir_b,
  input wire logic [7:0] dir_c,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [15:0] feedback,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [3:0] port_c_in,
  input wire cml_pkg::cml_in_t in_mode [20],
  input wire logic [4:0] in_term,
  input wire logic [4:0] in_use_ale,
  output logic [19:0] input_cell_out
);
  import cml_pkg::*;

  function automatic logic rise(logic now, logic was);
    return now & ~was;
  endfunction
  function automatic logic ff_next(cml_ff_t ty, logic q, logic a, logic b);
    case (ty)
      CML_FF_T: ff_next = q ^ a;
      CML_FF_JK: ff_next = (a & ~q) | (~b & q);
      CML_FF_SR: ff_next = a | (q & ~b);
      default: ff_next = a;
    endcase
  endfunction

  function automatic int native(int i);
    return (i < 8) ? AB_NATIVE : BC_NATIVE; // RL7
  endfunction
  function automatic int up_cap(int i);
    return (i < 8) ? AB_UP_CAP : ((i < 12) ? BC_LO_UP_CAP : BC_HI_UP_CAP); // RL7
  endfunction
  // a lent term is granted only if its owner does not use it
  function automatic logic lent(int j, int t, logic up);
    return term_val[4*j+t] & term_lend[4*j+t] & ~term_own[4*j+t]
      & (term_lend_up[4*j+t] == up); // RL8
  endfunction

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // pins and the logic clock pin: two flops before any use
  logic [20:0] pin_s1_q, pin_s2_q;
  logic pin_clk_q, sel_wr_q;
  logic [7:0] wa_q, wd_q, ab_mask_q, bc_mask_q;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {logic_clock_input, port_c_in, port_b_in, port_a_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire sel_wr = register_block_select & ~wr_strobe_n; // RL22
  wire sel_rd = register_block_select & ~rd_strobe_n; // RL22
  // edge loading uses the address and data held during the strobe
  wire load_now = edge_load ? rise(sel_wr_q, sel_wr) : sel_wr; // RL12
  wire [7:0] ld_addr = edge_load ? wa_q : reg_addr;
  wire [7:0] ld_data = edge_load ? wd_q : wr_data;
  wire ld_ab = load_now & (ld_addr == OFS_AB_STATE);
  wire ld_bc = load_now & (ld_addr == OFS_BC_STATE);
  wire [15:0] ld_cell = {{8{ld_bc}} & ~bc_mask_q, {8{ld_ab}} & ~ab_mask_q}; // RL13

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sel_wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      ab_mask_q <= MASK_RST; // RL13
      bc_mask_q <= MASK_RST;
    end else begin
      sel_wr_q <= sel_wr;
      if (sel_wr) begin
        wa_q <= reg_addr;
        wd_q <= wr_data;
      end
      if (load_now && ld_addr == OFS_AB_MASK) ab_mask_q <= ld_data;
      if (load_now && ld_addr == OFS_BC_MASK) bc_mask_q <= ld_data;
    end
  end

  AST_MASK_RESET: assert property ($rose(nrst) |-> ab_mask_q == MASK_RST // RL13
    && bc_mask_q == MASK_RST) else $error("mask not cleared by reset");
  AST_MASK_BLOCK: assert property (ld_ab && ab_mask_q[1] |-> !ld_cell[1]) // RL13
    else $error("masked cell accepted a load");
  AST_EDGE_WAIT: assert property (edge_load && sel_wr |-> !load_now) // RL12
    else $error("edge load fired inside the strobe");

  // product term sums with borrowing and expansion
  logic [15:0] sum_w, comb_q, state_q, state_d, clk_term_q, sel_w;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      // expansion reads another cell's registered sum: one cell delay
      sum_w[i] = expand_en[i] & comb_q[(i + 1) % 16]; // RL9
      for (int t = 0; t < 4; t++) begin
        if (t < native(i)) sum_w[i] = sum_w[i] | (term_val[4*i+t] & term_own[4*i+t]);
        if (i % 8 != 0 && t < native((i + 15) % 16))
          sum_w[i] = sum_w[i] | lent((i + 15) % 16, t, 1'b1); // RL8
        if (i % 8 != 7 && t < up_cap(i))
          sum_w[i] = sum_w[i] | lent((i + 1) % 16, t, 1'b0); // RL8
      end
    end
  end
  wire [15:0] xor_w = sum_w ^ polarity; // RL2
  wire pin_rise = rise(pin_s2_q[20], pin_clk_q); // RL5

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (ld_cell[i]) state_d[i] = ld_data[i % 8]; // RL10 RL11
      else if (clear_term[2*i] | clear_term[2*i+1]) state_d[i] = 1'b0; // RL6
      else if (preset_term[i]) state_d[i] = 1'b1; // RL6
      else if (clk_from_pin[i] ? pin_rise : rise(clk_term[i], clk_term_q[i])) // RL5
        state_d[i] = ff_next(ff_type[i], state_q[i], xor_w[i], k_sum[i]); // RL4
      else state_d[i] = state_q[i];
    end
  end
  assign sel_w = (reg_sel & state_q) | (~reg_sel & comb_q); // RL3

  always_ff @(posedge clock) begin
    if (!nrst) begin
      comb_q <= STATE_RST;
      state_q <= STATE_RST;
      clk_term_q <= 16'h0000;
      pin_clk_q <= 1'b0;
    end else begin
      comb_q <= xor_w;
      state_q <= state_d;
      clk_term_q <= clk_term;
      pin_clk_q <= pin_s2_q[20];
    end
  end

  AST_LOAD_WINS: assert property (ld_cell[0] |=> state_q[0] == $past(ld_data[0])) // RL10
    else $error("load did not win over flop inputs");
  AST_CLEAR: assert property (clear_term[1] && !ld_cell[0] |=> !state_q[0]) // RL6
    else $error("second clear term ignored");
  AST_POLARITY: assert property (polarity[8] && sum_w[8] |=> !comb_q[8]) // RL2
    else $error("polarity not applied");
  AST_PIN_CLOCK: assert property (clk_from_pin[8] && ff_type[8] == CML_FF_D && pin_rise // RL5
    && !ld_cell[8] && !preset_term[8] && !(clear_term[16] | clear_term[17])
    |=> state_q[8] == $past(xor_w[8])) else $error("pin clock edge missed");
  AST_T_TOGGLE: assert property (clk_from_pin[8] && ff_type[8] == CML_FF_T // RL4
    && xor_w[8] && pin_rise && !ld_cell[8] && !preset_term[8]
    && !clear_term[16] && !clear_term[17] |=> state_q[8] != $past(state_q[8]))
    else $error("t flop did not toggle");

  // pin routing and enables
  logic [7:0] a_out_q, a_oe_q, b_out_q, b_oe_q, c_out_q, c_oe_q;
  logic [7:0] a_out_d, a_oe_d, b_out_d, b_oe_d, c_out_d, c_oe_d;
  logic [15:0] drv_w, oe_w, fb_q;
  assign drv_w = pin_output & ~internal_node; // RL16
  assign oe_w = oe_term | ~oe_defined; // RL14 RL15
  wire [7:0] ab_on_b = ab_to_b | {8{small_package}}; // RL17
  wire [7:0] bc_on_c = bc_to_c & BC_C_OK; // RL17
  always_comb begin
    {a_out_d, a_oe_d, b_out_d, b_oe_d, c_out_d, c_oe_d} = '0;
    for (int b = 0; b < 8; b++) begin
      if (drv_w[b] && !ab_on_b[b]) begin // RL1
        a_out_d[b] = sel_w[b];
        a_oe_d[b] = oe_w[b] | dir_a[b]; // RL14
      end
      // ab has the port b pin when both groups claim it
      if (drv_w[b] && ab_on_b[b]) begin
        b_out_d[b] = sel_w[b];
        b_oe_d[b] = oe_w[b] | dir_b[b];
      end else if (drv_w[b+8] && !bc_on_c[b]) begin
        b_out_d[b] = sel_w[b+8];
        b_oe_d[b] = oe_w[b+8] | dir_b[b];
      end
      if (drv_w[b+8] && bc_on_c[b]) begin // RL1
        c_out_d[b] = sel_w[b+8];
        c_oe_d[b] = oe_w[b+8] | dir_c[b];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      {a_out_q, a_oe_q, b_out_q, b_oe_q, c_out_q, c_oe_q} <= '0;
      fb_q <= STATE_RST;
    end else begin
      {a_out_q, a_oe_q, b_out_q, b_oe_q} <= {a_out_d, a_oe_d, b_out_d, b_oe_d};
      {c_out_q, c_oe_q} <= {c_out_d, c_oe_d};
      fb_q <= sel_w; // RL3 RL16
    end
  end
  assign port_a_out = a_out_q;
  assign port_a_oe = a_oe_q;
  assign port_b_out = b_out_q;
  assign port_b_oe = b_oe_q;
  assign port_c_out = c_out_q;
  assign port_c_oe = c_oe_q;
  assign feedback = fb_q;

  AST_TEST_PINS: assert property ((port_c_oe & ~BC_C_OK) == 8'h00) // RL17
    else $error("test port pin driven by a cell");
  AST_SMALL_PKG: assert property (small_package |=> port_a_oe == 8'h00) // RL17
    else $error("port a driven in small package");
  AST_INTERNAL: assert property (internal_node[3] && internal_node[11] // RL16
    |=> !port_a_oe[3] && !port_b_oe[3]) else $error("internal node drove a pin");
  AST_FEEDBACK: assert property (reg_sel[2] |=> feedback[2] == $past(state_q[2])) // RL3
    else $error("feedback not from flop");
  AST_NO_OE_EQN: assert property (drv_w[0] && !ab_on_b[0] && !oe_defined[0] // RL15
    |=> port_a_oe[0]) else $error("output without enable equation off");

  // input cells: enable per group of four
  logic [4:0] en_w, en_q;
  logic [19:0] in_q, in_d;
  assign en_w = (in_use_ale & {5{addr_latch_strobe}}) | (~in_use_ale & in_term); // RL19
  always_comb begin
    for (int k = 0; k < 20; k++) begin
      case (in_mode[k]) // RL18
        CML_IN_LATCH: in_d[k] = en_w[k/4] ? pin_s2_q[k] : in_q[k]; // RL20
        CML_IN_REG: in_d[k] = rise(en_w[k/4], en_q[k/4]) ? pin_s2_q[k] : in_q[k];
        default: in_d[k] = pin_s2_q[k];
      endcase
    end
  end

  // read port: cells, masks and input cells, zero elsewhere
  logic [7:0] rd_w, rd_q;
  logic rd_oe_q;
  always_comb begin
    case (reg_addr) // RL23
      OFS_AB_STATE: rd_w = state_q[7:0]; // RL11
      OFS_BC_STATE: rd_w = state_q[15:8];
      OFS_AB_MASK: rd_w = ab_mask_q;
      OFS_BC_MASK: rd_w = bc_mask_q;
      OFS_IN_A: rd_w = in_q[7:0]; // RL21
      OFS_IN_B: rd_w = in_q[15:8];
      OFS_IN_C: rd_w = {4'h0, in_q[19:16]};
      default: rd_w = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      en_q <= 5'h00;
      in_q <= IN_RST;
      rd_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else begin
      en_q <= en_w;
      in_q <= in_d;
      rd_q <= sel_rd ? rd_w : 8'h00;
      rd_oe_q <= sel_rd;
    end
  end
  assign input_cell_out = in_q; // RL21
  assign rd_data = rd_q;
  assign rd_data_oe = rd_oe_q;

  AST_IN_PASS: assert property (in_mode[0] == CML_IN_PASS // RL18
    |=> input_cell_out[0] == $past(pin_s2_q[0])) else $error("pass-through mismatch");
  AST_READ_IN: assert property (sel_rd && reg_addr == OFS_IN_B // RL21
    |=> rd_data_oe && rd_data == $past(input_cell_out[15:8])) else $error("bad read");
  AST_NO_SELECT: assert property (!register_block_select |=> !rd_data_oe) // RL22
    else $error("read without block select");

  COV_EDGE_LOAD: cover property (edge_load && ld_ab);
  COV_MASKED: cover property (ld_bc && bc_mask_q != 8'h00);
  COV_PIN_CLK: cover property (pin_rise && clk_from_pin[0]);
  COV_IN_REG: cover property (in_mode[12] == CML_IN_REG && rise(en_w[3], en_q[3]));
endmodule
`default_nettype wire

// *** cml_pkg.sv ***
// Purpose: shared constants and types of the logic macrocell array
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: register offsets are fixed here for the whole register block
package cml_pkg;
  // offsets inside the register block; RL23
  localparam logic [7:0] OFS_AB_STATE = 8'h00;
  localparam logic [7:0] OFS_BC_STATE = 8'h01;
  localparam logic [7:0] OFS_AB_MASK = 8'h02;
  localparam logic [7:0] OFS_BC_MASK = 8'h03;
  localparam logic [7:0] OFS_IN_A = 8'h04;
  localparam logic [7:0] OFS_IN_B = 8'h05;
  localparam logic [7:0] OFS_IN_C = 8'h06;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] STATE_RST = 16'h0000;
  localparam logic [19:0] IN_RST = 20'h00000;
  // port c bits 2,3,4,7 only; the rest belong to the test port
  localparam logic [7:0] BC_C_OK = 8'h9C;
  localparam int AB_NATIVE = 3;
  localparam int BC_NATIVE = 4;
  localparam int AB_UP_CAP = 3;
  localparam int BC_LO_UP_CAP = 1;
  localparam int BC_HI_UP_CAP = 2;
  typedef enum logic [1:0] {CML_FF_D, CML_FF_T, CML_FF_JK, CML_FF_SR} cml_ff_t;
  typedef enum logic [1:0] {CML_IN_PASS, CML_IN_LATCH, CML_IN_REG} cml_in_t;
endpackage

// *** test_cml_macrocell_array.sv ***
// Purpose: self-checking bench for the macrocell array
// Assumes: level loading unless a test selects edge loading
// Notes: register cases run from a table; pins and cells are hand tests after it
`timescale 1ns/1ps
`default_nettype none
module test_cml_macrocell_array;
  import cml_pkg::*;
  logic clock, nrst = 1'b0, edge_load = 1'b0, addr_latch_strobe = 1'b0;
  logic logic_clock_input = 1'b0, small_package = 1'b0, register_block_select;
  logic wr_strobe_n, rd_strobe_n, rd_data_oe, oe;
  logic [7:0] reg_addr, wr_data, rd_data, port_a_out, port_a_oe, port_b_out, port_b_oe;
  logic [7:0] port_c_out, port_c_oe, ab_to_b = '0, bc_to_c = '0, dir_a = '0, dir_b = '0;
  logic [7:0] dir_c = '0, port_a_in = '0, port_b_in = '0, d;
  logic [63:0] term_val = '0, term_own = '0, term_lend = '0, term_lend_up = '0;
  logic [15:0] expand_en = '0, polarity = '0, reg_sel = '1, k_sum = '0, clk_term = '0;
  logic [15:0] clk_from_pin = '0, preset_term = '0, pin_output = '1, oe_defined = '0;
  logic [15:0] oe_term = '0, internal_node = '0, feedback;
  logic [31:0] clear_term = '0;
  logic [3:0] port_c_in = '0;
  logic [4:0] in_term = '0, in_use_ale = '0;
  logic [19:0] input_cell_out;
  cml_ff_t ff_type [16] = '{default: CML_FF_D};
  cml_in_t in_mode [20] = '{default: CML_IN_PASS};
  int errors = 0, checks_done = 0, cycles = 0;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} cml_row_t;
  localparam cml_row_t ROWS [9] = '{
    '{OFS_AB_STATE, 8'hA5, 8'hA5}, '{OFS_BC_STATE, 8'h3C, 8'h3C},
    '{OFS_AB_MASK, 8'h0F, 8'h0F}, '{OFS_AB_STATE, 8'hFF, 8'hF5},
    '{OFS_BC_MASK, 8'hF0, 8'hF0}, '{OFS_BC_STATE, 8'h00, 8'h30},
    '{OFS_AB_MASK, 8'h00, 8'h00}, '{OFS_BC_MASK, 8'h00, 8'h00}, '{8'h7F, 8'h55, 8'h00}};
  cml_cpu_model cpu (.clock, .register_block_select, .reg_addr, .wr_strobe_n, .rd_strobe_n,
    .wr_data, .rd_data, .rd_data_oe);
  cml_macrocell_array dut (.clock, .nrst, .register_block_select, .reg_addr, .wr_strobe_n,
    .rd_strobe_n, .wr_data, .rd_data, .rd_data_oe, .edge_load, .addr_latch_strobe,
    .logic_clock_input, .term_val, .term_own, .term_lend, .term_lend_up, .expand_en,
    .polarity, .reg_sel, .ff_type, .k_sum, .clk_term, .clk_from_pin, .preset_term,
    .clear_term, .pin_output, .oe_defined, .oe_term, .internal_node, .ab_to_b, .bc_to_c,
    .small_package, .dir_a, .dir_b, .dir_c, .port_a_out, .port_a_oe, .port_b_out,
    .port_b_oe, .port_c_out, .port_c_oe, .feedback, .port_a_in, .port_b_in, .port_c_in,
    .in_mode, .in_term, .in_use_ale, .input_cell_out);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk_pin(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_pin({12'h000, got}, {12'h000, exp});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    cpu.rd(a, d, oe);
    chk_reg(d, e);
    chk_reg({7'h00, oe}, 8'h01);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  initial begin
    tk(16);
    nrst <= 1'b1;
    chk_pin({4'h0, feedback}, 20'h00000);
    tk(3);
    chk_pin({4'h0, port_b_oe, port_a_oe}, 20'h0FFFF);
    rdc(OFS_AB_MASK, MASK_RST);
    rdc(OFS_BC_MASK, MASK_RST);
    foreach (ROWS[i]) begin
      cpu.wr(ROWS[i].a, ROWS[i].w, 1'b1, 1);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    tk(3);
    chk_pin({4'h0, feedback}, 20'h030F5);
    chk_pin({4'h0, port_b_out, port_a_out}, 20'h030F5);
    ab_to_b <= 8'h01;
    tk(3);
    chk_pin({4'h0, port_b_out, port_a_oe}, 20'h031FE);
    ab_to_b <= 8'h00;
    cpu.wr(OFS_AB_STATE, 8'h00, 1'b0, 1);
    rdc(OFS_AB_STATE, 8'hF5);
    edge_load <= 1'b1;
    cpu.wr(OFS_AB_STATE, 8'h3C, 1'b1, 4);
    tk(2);
    rdc(OFS_AB_STATE, 8'h3C);
    edge_load <= 1'b0;
    small_package <= 1'b1;
    bc_to_c <= 8'hFF;
    tk(4);
    chk_pin({4'h0, port_a_oe, port_b_out}, 20'h0003C);
    chk_pin({4'h0, port_c_oe, port_c_out & port_c_oe}, {4'h0, BC_C_OK, 8'h10});
    oe_defined <= 16'hFFFF;
    oe_term <= 16'h0001;
    dir_b <= 8'h0E;
    tk(4);
    chk_pin({12'h000, port_b_oe}, 20'h0000F);
    dir_b <= 8'h00;
    internal_node <= 16'hFFFF;
    tk(4);
    chk_pin({4'h0, port_b_oe, port_a_oe}, 20'h00000);
    chk_pin({4'h0, feedback}, 20'h0303C);
    internal_node <= 16'h0000;
    preset_term <= 16'h0001;
    tk(3);
    rdc(OFS_AB_STATE, 8'h3D);
    clear_term <= 32'h00000002;
    tk(3);
    rdc(OFS_AB_STATE, 8'h3C);
    preset_term <= 16'h0000;
    clear_term <= 32'h00000000;
    term_own[32] <= 1'b1;
    term_val[32] <= 1'b1;
    reg_sel[8] <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      polarity[8] <= p[0];
      tk(4);
      chk_pin({19'h0, feedback[8]}, {19'h0, ~p[0]});
    end
    reg_sel[8] <= 1'b1;
    polarity[8] <= 1'b0;
    clk_from_pin[8] <= 1'b1;
    // the pin edge comes only after the load, so every element type ends at one
    for (int t = 0; t < 4; t++) begin
      ff_type[8] <= cml_ff_t'(t);
      cpu.wr(OFS_BC_STATE, 8'h30, 1'b1, 1);
      logic_clock_input <= 1'b1;
      tk(6);
      rdc(OFS_BC_STATE, 8'h31);
      logic_clock_input <= 1'b0;
      tk(3);
    end
    // cell 9 lends lanes to cell 8; only lanes below the cap may pass
    term_val[32] <= 1'b0;
    reg_sel[8] <= 1'b0;
    term_val[37:36] <= 2'b11;
    term_lend[37:36] <= 2'b11;
    tk(4);
    chk_pin({19'h0, feedback[8]}, 20'h00001);
    term_val[36] <= 1'b0;
    tk(4);
    chk_pin({19'h0, feedback[8]}, 20'h00000);
    term_val[36] <= 1'b1;
    term_own[36] <= 1'b1;
    tk(4);
    chk_pin({19'h0, feedback[8]}, 20'h00000);
    expand_en[8] <= 1'b1;
    tk(4);
    chk_pin({19'h0, feedback[8]}, 20'h00001);
    expand_en[8] <= 1'b0;
    port_a_in <= 8'h5A;
    port_c_in <= 4'hA;
    for (int i = 0; i < 8; i++)
      in_mode[i] <= CML_IN_LATCH;
    in_term <= 5'h03;
    tk(5);
    chk_pin(input_cell_out, 20'hA005A);
    rdc(OFS_IN_C, 8'h0A);
    in_term <= 5'h00;
    port_a_in <= 8'hA5;
    tk(5);
    rdc(OFS_IN_A, 8'h5A);
    in_term <= 5'h01;
    tk(5);
    rdc(OFS_IN_A, 8'h55);
    for (int i = 8; i < 16; i++)
      in_mode[i] <= CML_IN_REG;
    in_use_ale <= 5'h0C;
    port_b_in <= 8'hC3;
    tk(5);
    rdc(OFS_IN_B, 8'h00);
    addr_latch_strobe <= 1'b1;
    tk(1);
    addr_latch_strobe <= 1'b0;
    tk(3);
    rdc(OFS_IN_B, 8'hC3);
    tk(2);
    summarize();
  end
endmodule
`default_nettype wire
